// [core/pbd_pkg.sv]
// Package: register map, control bit positions, reset values and memory request carrier
//
// Notes on behaviour
// - Copies run forward, starting at the first source byte, ascending through the range.
// - Overlapping moves to a lower address work; the trailing uncovered byte stays unchanged.
// - Even source to the preceding odd destination copies correctly, last byte untouched.
// - Checksum runs alone over a range or alongside a copy over moved bytes.
// - Checksum reads source bytes as big-endian 16-bit words, first byte high.
// - Odd byte count pads a zero low byte for the sum only, never written.
// - Result is the complement of the end-around-carry one's complement sum.
// - Copy select set copies, clear sums only; sum disable clear enables summing.
// - Seed select clear starts the accumulator at zero.
// - Seed select set starts from the complement of the prior result register.
// - Finished checksum stays in the result register for the host to read.
// - Go bit starts the operation; hardware clears it at the end, with done pulse.
// - Throughput scales with mode: sum fastest, aligned copy adds a write per word, misaligned copies one byte per read and write.
// - Engine runs independently, sharing memory with other masters through a grant.
// - Cryptographic area is reached only through this engine, never the host ports.
// - Clearing the go bit during an operation cancels it.
// - Pointers wrap: user area first, then general buffer, then receive buffer end.
// - Ranges are SRAM and crypto area, no register space; zero length is legal.
package pbd_pkg;

  // ****************************************************************
  // Register offsets on the host port
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SRC = 4'h1;
  localparam logic [3:0] REG_DST = 4'h2;
  localparam logic [3:0] REG_LEN = 4'h3;
  localparam logic [3:0] REG_SUM = 4'h4;
  localparam logic [3:0] REG_RX_START = 4'h5;
  localparam logic [3:0] REG_UDA_START = 4'h6;
  localparam logic [3:0] REG_UDA_END = 4'h7;

  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int BIT_GO = 5;
  localparam int BIT_COPY = 4;
  localparam int BIT_SEED = 3;
  localparam int BIT_NOSUM = 2;

  // ****************************************************************
  // Reset values and memory map limits
  // ****************************************************************
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [15:0] RST_SUM = 16'h0000;
  localparam logic [15:0] RST_RX_START = 16'h3000;
  localparam logic [15:0] RST_UDA_START = 16'h0000;
  localparam logic [15:0] RST_UDA_END = 16'h0000;
  localparam logic [15:0] SRAM_LAST = 16'h5FFF;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ****************************************************************
  // Memory request carrier
  // ****************************************************************
  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } pbd_mem_req_t;

endpackage : pbd_pkg

// [core/pbd_sum_acc.sv]
// One's complement checksum accumulator with end-around carry
`timescale 1ns/1ps
module pbd_sum_acc (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [15:0] seed,
  input wire logic add_en,
  input wire logic [15:0] word,
  // Result
  output logic [15:0] acc
);

  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [16:0] wide;

  // Next accumulator: load wins, else fold the carry back in
  always_comb begin
    wide = {1'b0, acc_q} + {1'b0, word};
    acc_d = acc_q;
    if (load) begin
      acc_d = seed;
    end else if (add_en) begin
      acc_d = wide[15:0] + {15'h0000, wide[16]};
    end
  end

  // Accumulator register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign acc = acc_q;

endmodule : pbd_sum_acc

// [core/pbd_dma.sv]
// Packet buffer DMA engine with copy and IP checksum, register port and memory master
`timescale 1ns/1ps
module pbd_dma (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Memory master port, shared with other masters
  output pbd_pkg::pbd_mem_req_t mem_out,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata,
  // Completion
  output logic op_done
);

  // ****************************************************************
  // State and registers
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RD = 5'b00010,
    ST_RWAIT = 5'b00100,
    ST_WR = 5'b01000,
    ST_FIN = 5'b10000
  } pbd_state_t;

  pbd_state_t state_q, state_d;
  logic go_q, go_d;
  logic copy_q, copy_d;
  logic seed_q, seed_d;
  logic nosum_q, nosum_d;
  logic [15:0] src_q, src_d;
  logic [15:0] dst_q, dst_d;
  logic [15:0] len_q, len_d;
  logic [15:0] sum_q, sum_d;
  logic [15:0] rxst_q, rxst_d;
  logic [15:0] udast_q, udast_d;
  logic [15:0] udand_q, udand_d;
  logic [15:0] cur_src_q, cur_src_d;
  logic [15:0] cur_dst_q, cur_dst_d;
  logic [15:0] rem_q, rem_d;
  logic phase_q, phase_d;
  pbd_pkg::pbd_mem_req_t mem_q, mem_d;
  logic done_q, done_d;
  logic [15:0] rdata_q, rdata_d;

  // Checksum accumulator hookup
  logic acc_load;
  logic [15:0] acc_seed;
  logic acc_add;
  logic [15:0] acc_word;
  logic [15:0] acc_val;

  // Step decode
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic two_bytes;
  logic [15:0] src_n1;
  logic [15:0] src_n2;
  logic [15:0] dst_n1;
  logic [15:0] dst_n2;
  logic ctrl_wr;

  // ****************************************************************
  // Address wrap
  // ****************************************************************
  // User area end beats general buffer end beats the receive buffer end
  function automatic logic [15:0] wrap_next(input logic [15:0] a);
    logic [15:0] r;
    r = a + 16'h0001;
    if (a == udand_q) begin
      r = udast_q;
    end else if (a == (rxst_q - 16'h0001)) begin
      r = 16'h0000;
    end else if (a == pbd_pkg::SRAM_LAST) begin
      r = rxst_q;
    end
    return r;
  endfunction : wrap_next

  // ****************************************************************
  // Step decode from the fetched source word
  // ****************************************************************
  // Even bytes sit in the low lane of a word, odd bytes in the high lane
  always_comb begin
    src_n1 = wrap_next(cur_src_q);
    src_n2 = wrap_next(src_n1);
    dst_n1 = wrap_next(cur_dst_q);
    dst_n2 = wrap_next(dst_n1);
    byte0 = cur_src_q[0] ? mem_rdata[15:8] : mem_rdata[7:0];
    byte1 = mem_rdata[15:8];
    // Two bytes per step only when no wrap splits the word on either side
    two_bytes = !cur_src_q[0] && (rem_q > 16'h0001)
      && (src_n1 == cur_src_q + 16'h0001)
      && (!copy_q || (!cur_dst_q[0] && (dst_n1 == cur_dst_q + 16'h0001)));
  end

  // ****************************************************************
  // Register file and engine next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    go_d = go_q;
    copy_d = copy_q;
    seed_d = seed_q;
    nosum_d = nosum_q;
    src_d = src_q;
    dst_d = dst_q;
    len_d = len_q;
    sum_d = sum_q;
    rxst_d = rxst_q;
    udast_d = udast_q;
    udand_d = udand_q;
    cur_src_d = cur_src_q;
    cur_dst_d = cur_dst_q;
    rem_d = rem_q;
    phase_d = phase_q;
    mem_d = mem_q;
    done_d = 1'b0;
    acc_load = 1'b0;
    acc_seed = 16'h0000;
    acc_add = 1'b0;
    acc_word = 16'h0000;
    ctrl_wr = reg_wr && (reg_addr == pbd_pkg::REG_CTRL);

    // Host writes; the port only reaches registers, never the memory
    if (reg_wr && (state_q == ST_IDLE)) begin
      unique case (reg_addr)
        pbd_pkg::REG_CTRL: begin
          copy_d = reg_wdata[pbd_pkg::BIT_COPY];
          seed_d = reg_wdata[pbd_pkg::BIT_SEED];
          nosum_d = reg_wdata[pbd_pkg::BIT_NOSUM];
        end
        pbd_pkg::REG_SRC: src_d = reg_wdata;
        pbd_pkg::REG_DST: dst_d = reg_wdata;
        pbd_pkg::REG_LEN: len_d = reg_wdata;
        pbd_pkg::REG_SUM: sum_d = reg_wdata;
        pbd_pkg::REG_RX_START: rxst_d = reg_wdata;
        pbd_pkg::REG_UDA_START: udast_d = reg_wdata;
        pbd_pkg::REG_UDA_END: udand_d = reg_wdata;
        default: ;
      endcase
    end

    unique case (state_q)
      ST_IDLE: begin
        if (ctrl_wr && reg_wdata[pbd_pkg::BIT_GO]) begin
          go_d = 1'b1;
          cur_src_d = src_q;
          cur_dst_d = dst_q;
          rem_d = len_q;
          phase_d = 1'b0;
          acc_load = 1'b1;
          // Seed from the previous result or from zero
          acc_seed = reg_wdata[pbd_pkg::BIT_SEED] ? ~sum_q : 16'h0000;
          if (len_q == 16'h0000) begin
            state_d = ST_FIN;
          end else begin
            state_d = ST_RD;
            mem_d.req = 1'b1;
            mem_d.we = 1'b0;
            mem_d.addr = src_q[15:1];
            mem_d.be = 2'h3;
          end
        end
      end
      ST_RD: begin
        // Hold the read until the shared memory grants it
        if (mem_gnt) begin
          mem_d.req = 1'b0;
          state_d = ST_RWAIT;
        end
      end
      ST_RWAIT: begin
        if (mem_rvalid) begin
          // Feed the sum; a lone byte fills its own lane, zero pad elsewhere
          acc_add = !nosum_q;
          if (two_bytes) begin
            acc_word = phase_q ? {byte1, byte0} : {byte0, byte1};
            rem_d = rem_q - 16'h0002;
            cur_src_d = src_n2;
          end else begin
            acc_word = phase_q ? {pbd_pkg::PAD_BYTE, byte0} : {byte0, pbd_pkg::PAD_BYTE};
            phase_d = !phase_q;
            rem_d = rem_q - 16'h0001;
            cur_src_d = src_n1;
          end
          if (copy_q) begin
            // Only real bytes are written, the pad never reaches memory
            state_d = ST_WR;
            mem_d.req = 1'b1;
            mem_d.we = 1'b1;
            mem_d.addr = cur_dst_q[15:1];
            if (two_bytes) begin
              mem_d.wdata = {byte1, byte0};
              mem_d.be = 2'h3;
              cur_dst_d = dst_n2;
            end else begin
              mem_d.wdata = {byte0, byte0};
              mem_d.be = cur_dst_q[0] ? 2'h2 : 2'h1;
              cur_dst_d = dst_n1;
            end
          end else if (rem_d == 16'h0000) begin
            state_d = ST_FIN;
          end else begin
            state_d = ST_RD;
            mem_d.req = 1'b1;
            mem_d.we = 1'b0;
            mem_d.addr = cur_src_d[15:1];
            mem_d.be = 2'h3;
          end
        end
      end
      ST_WR: begin
        // Each source word is read before its write, so downward overlap is safe
        if (mem_gnt) begin
          if (rem_q == 16'h0000) begin
            mem_d.req = 1'b0;
            mem_d.we = 1'b0;
            state_d = ST_FIN;
          end else begin
            mem_d.req = 1'b1;
            mem_d.we = 1'b0;
            mem_d.addr = cur_src_q[15:1];
            mem_d.be = 2'h3;
            state_d = ST_RD;
          end
        end
      end
      ST_FIN: begin
        // When summing is on, the accumulator now holds every word; store its complement
        if (!nosum_q) begin
          sum_d = ~acc_val;
        end
        go_d = 1'b0;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        go_d = 1'b0;
        mem_d.req = 1'b0;
      end
    endcase

    // Go cleared by the host abandons the run, memory request dropped at once
    if (ctrl_wr && !reg_wdata[pbd_pkg::BIT_GO] && (state_q != ST_IDLE)) begin
      state_d = ST_IDLE;
      go_d = 1'b0;
      mem_d.req = 1'b0;
      mem_d.we = 1'b0;
    end
  end

  // ****************************************************************
  // Register read mux, answered one cycle later
  // ****************************************************************
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        pbd_pkg::REG_CTRL: begin
          rdata_d[pbd_pkg::BIT_GO] = go_q;
          rdata_d[pbd_pkg::BIT_COPY] = copy_q;
          rdata_d[pbd_pkg::BIT_SEED] = seed_q;
          rdata_d[pbd_pkg::BIT_NOSUM] = nosum_q;
        end
        pbd_pkg::REG_SRC: rdata_d = src_q;
        pbd_pkg::REG_DST: rdata_d = dst_q;
        pbd_pkg::REG_LEN: rdata_d = len_q;
        pbd_pkg::REG_SUM: rdata_d = sum_q;
        pbd_pkg::REG_RX_START: rdata_d = rxst_q;
        pbd_pkg::REG_UDA_START: rdata_d = udast_q;
        pbd_pkg::REG_UDA_END: rdata_d = udand_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      go_q <= 1'b0;
      copy_q <= 1'b0;
      seed_q <= 1'b0;
      nosum_q <= 1'b0;
      src_q <= pbd_pkg::RST_PTR;
      dst_q <= pbd_pkg::RST_PTR;
      len_q <= pbd_pkg::RST_PTR;
      sum_q <= pbd_pkg::RST_SUM;
      rxst_q <= pbd_pkg::RST_RX_START;
      udast_q <= pbd_pkg::RST_UDA_START;
      udand_q <= pbd_pkg::RST_UDA_END;
      cur_src_q <= pbd_pkg::RST_PTR;
      cur_dst_q <= pbd_pkg::RST_PTR;
      rem_q <= pbd_pkg::RST_PTR;
      phase_q <= 1'b0;
      mem_q <= '0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      go_q <= go_d;
      copy_q <= copy_d;
      seed_q <= seed_d;
      nosum_q <= nosum_d;
      src_q <= src_d;
      dst_q <= dst_d;
      len_q <= len_d;
      sum_q <= sum_d;
      rxst_q <= rxst_d;
      udast_q <= udast_d;
      udand_q <= udand_d;
      cur_src_q <= cur_src_d;
      cur_dst_q <= cur_dst_d;
      rem_q <= rem_d;
      phase_q <= phase_d;
      mem_q <= mem_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Checksum accumulator and outputs
  // ****************************************************************
  pbd_sum_acc u_sum (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(acc_load),
    .seed(acc_seed),
    .add_en(acc_add),
    .word(acc_word),
    .acc(acc_val)
  );

  assign mem_out = mem_q;
  assign reg_rdata = rdata_q;
  assign op_done = done_q;

endmodule : pbd_dma

// [verif/pbd_mem_model.sv]
// Behavioural packet memory answering the DMA master port
`timescale 1ns/1ps
module pbd_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Stall control from the bench
  input wire logic slow,
  // Memory port
  input pbd_pkg::pbd_mem_req_t mem_out,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:32767];
  logic [1:0] dly_q;
  logic pend_q;
  logic tog_q;
  logic [14:0] ra_q;

  // Other masters take every second slot when slow
  assign mem_gnt = !slow || tog_q;

  // Stale read data is inverted each cycle so it never looks valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tog_q <= 1'b0;
      pend_q <= 1'b0;
      dly_q <= 2'h0;
      ra_q <= 15'h0000;
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      tog_q <= ~tog_q;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && mem_gnt) begin
        if (mem_out.we) begin
          if (mem_out.be[0]) mem[mem_out.addr][7:0] <= mem_out.wdata[7:0];
          if (mem_out.be[1]) mem[mem_out.addr][15:8] <= mem_out.wdata[15:8];
        end else begin
          pend_q <= 1'b1;
          ra_q <= mem_out.addr;
          dly_q <= slow ? 2'h2 : 2'h0;
        end
      end
      if (pend_q) begin
        if (dly_q == 2'h0) begin
          pend_q <= 1'b0;
          mem_rvalid <= 1'b1;
          mem_rdata <= mem[ra_q];
        end else begin
          dly_q <= dly_q - 2'h1;
        end
      end
    end
  end
endmodule : pbd_mem_model

// [verif/pbd_dma_asserts.sv]
// Port checks for the packet buffer DMA engine
`timescale 1ns/1ps
module pbd_dma_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Memory port
  input pbd_pkg::pbd_mem_req_t mem_out,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata,
  // Completion
  input wire logic op_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Register port, completion and memory requests
  // ****************************************************************
  a_rdata_after_rd: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside a read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000)
    else $error("unmapped index read nonzero");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("completion pulse too long");
  a_done_bus_idle: assert property (op_done |-> !mem_out.req)
    else $error("request pending at completion");
  a_cancel_drop: assert property (reg_wr && reg_addr == pbd_pkg::REG_CTRL &&
    !reg_wdata[pbd_pkg::BIT_GO] |=> !mem_out.req)
    else $error("request survived cancel");
  a_req_hold: assert property (mem_out.req && !mem_gnt && !reg_wr |=> $stable(mem_out))
    else $error("request changed before grant");
  a_one_read: assert property (mem_out.req && mem_gnt && !mem_out.we |=> !mem_out.req)
    else $error("second request before read data");
  a_lane_set: assert property (mem_out.req |-> mem_out.be != 2'h0)
    else $error("request with no byte lane");
  c_done: cover property (op_done);
  c_stall: cover property (mem_out.req && !mem_gnt);
  c_one_lane: cover property (mem_out.req && mem_out.we && mem_out.be != 2'h3);
endmodule : pbd_dma_chk

bind pbd_dma pbd_dma_chk chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_out(mem_out), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .op_done(op_done));

// [verif/testbench.sv]
// Self-checking bench for the packet buffer DMA engine
`timescale 1ns/1ps
module testbench;
  logic clk_sys, rst_n, reg_wr, reg_rd, slow, mem_gnt, mem_rvalid, op_done;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_rdata, v, p;
  pbd_pkg::pbd_mem_req_t mem_out;
  int bad_count, checks;
  logic [7:0] ref_b [0:127];

  pbd_dma DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .op_done(op_done));
  pbd_mem_model mem_i (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .mem_out(mem_out),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // ****************************************************************
  // Clock, bus tasks and reference model
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // One idle cycle between strobes keeps each driver assignment unique
  task automatic wr(input logic [3:0] a, input int d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= 16'(d);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  function automatic logic [15:0] bget(input int a);
    return 16'(a[0] ? mem_i.mem[a >> 1][15:8] : mem_i.mem[a >> 1][7:0]);
  endfunction : bget

  task automatic fill(input int a, input int n);
    for (int i = 0; i < n; i++) begin
      ref_b[i] = 8'h11 + 8'(i * 37);
      if (a[0] ^ i[0]) mem_i.mem[(a + i) >> 1][15:8] = ref_b[i];
      else mem_i.mem[(a + i) >> 1][7:0] = ref_b[i];
    end
  endtask : fill

  // Big-endian words, zero pad, end-around carry, complemented
  function automatic logic [15:0] csum(input int n, input logic [15:0] acc);
    logic [16:0] s;
    s = {1'b0, acc};
    for (int i = 0; i < n; i += 2) begin
      s = s + {ref_b[i], (i + 1 < n) ? ref_b[i + 1] : 8'h00};
      s = {1'b0, s[15:0]} + 17'(s[16]);
    end
    return ~s[15:0];
  endfunction : csum

  task automatic go(input int s, input int d, input int n, input logic [15:0] ctrl);
    rd(pbd_pkg::REG_CTRL, v);
    chk(16'(v[pbd_pkg::BIT_GO]), 16'h0000, "engine busy before start");
    wr(pbd_pkg::REG_SRC, s);
    wr(pbd_pkg::REG_DST, d);
    wr(pbd_pkg::REG_LEN, n);
    wr(pbd_pkg::REG_CTRL, ctrl);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (op_done === 1'b1) break;
    end
    chk(16'(op_done), 16'h0001, "no completion pulse");
    rd(pbd_pkg::REG_CTRL, v);
    chk(16'(v[pbd_pkg::BIT_GO]), 16'h0000, "go bit still set");
  endtask : go

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(pbd_pkg::REG_RX_START, v);
    chk(v, 16'h3000, "receive start reset");
    rd(pbd_pkg::REG_UDA_END, v);
    chk(v, 16'h0000, "user end reset");
    rd(4'hF, v);
    chk(v, 16'h0000, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_sum();
    ref_b[0] = 8'h89;
    mem_i.mem[128] = 16'hAB89;
    mem_i.mem[129][7:0] = 8'hCD;
    go(256, 0, 3, 16'h0020);
    rd(pbd_pkg::REG_SUM, v);
    chk(v, 16'hA953, "three byte sum");
    fill(272, 4);
    go(272, 0, 4, 16'h0028);
    rd(pbd_pkg::REG_SUM, v);
    chk(v, csum(4, 16'h56AC), "seeded sum");
    go(272, 0, 0, 16'h0020);
    rd(pbd_pkg::REG_SUM, v);
    chk(v, 16'hFFFF, "zero length sum");
    // Odd start: the first word is split across two fetches
    fill(289, 5);
    go(289, 0, 5, 16'h0020);
    rd(pbd_pkg::REG_SUM, v);
    chk(v, csum(5, 16'h0000), "odd start sum");
    $display("test sum done");
  endtask : t_sum

  task automatic t_overlap();
    slow <= 1'b1;
    fill(513, 65);
    go(513, 512, 65, 16'h0030);
    for (int i = 0; i < 65; i++) chk(bget(512 + i), 16'(ref_b[i]), "moved byte");
    chk(bget(577), 16'(ref_b[64]), "tail byte touched");
    rd(pbd_pkg::REG_SUM, v);
    chk(v, csum(65, 16'h0000), "copy sum");
    $display("test overlap done");
  endtask : t_overlap

  task automatic t_even_odd();
    slow <= 1'b0;
    rd(pbd_pkg::REG_SUM, p);
    fill(770, 8);
    go(770, 769, 8, 16'h0034);
    for (int i = 0; i < 7; i++) chk(bget(769 + i), 16'(ref_b[i]), "moved byte");
    chk(bget(776), 16'(ref_b[7]), "last byte");
    chk(bget(777), 16'(ref_b[7]), "tail byte touched");
    // Upward overlapping move goes through a spare buffer in two copies
    fill(1536, 6);
    go(1536, 2048, 6, 16'h0034);
    go(2048, 1538, 6, 16'h0034);
    for (int i = 0; i < 6; i++) chk(bget(1538 + i), 16'(ref_b[i]), "upward move");
    rd(pbd_pkg::REG_SUM, v);
    chk(v, p, "sum disabled yet written");
    $display("test even odd done");
  endtask : t_even_odd

  task automatic t_cancel();
    slow <= 1'b1;
    wr(pbd_pkg::REG_SRC, 16'h1000);
    wr(pbd_pkg::REG_DST, 16'h2000);
    wr(pbd_pkg::REG_LEN, 400);
    wr(pbd_pkg::REG_CTRL, 16'h0030);
    repeat (10) @(posedge clk_sys);
    wr(pbd_pkg::REG_CTRL, 16'h0000);
    rd(pbd_pkg::REG_CTRL, v);
    chk(16'(v[pbd_pkg::BIT_GO]), 16'h0000, "cancel kept go");
    rd(pbd_pkg::REG_SUM, v);
    chk(v, p, "cancel changed sum");
    $display("test cancel done");
  endtask : t_cancel

  task automatic t_wrap();
    slow <= 1'b0;
    wr(pbd_pkg::REG_UDA_START, 16'h0400);
    wr(pbd_pkg::REG_UDA_END, 16'h0403);
    fill(1024, 4);
    go(1026, 1280, 4, 16'h0034);
    for (int i = 0; i < 4; i++) chk(bget(1280 + i), 16'(ref_b[(i + 2) % 4]), "wrap");
    $display("test wrap done");
  endtask : t_wrap

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    slow = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_sum();
    t_overlap();
    t_even_odd();
    t_cancel();
    t_wrap();
    summarize();
  end

  // Tests need a few thousand cycles; 50000 means a hang
  initial begin
    #2000000;
    bad_count++;
    summarize();
  end
endmodule : testbench
